// ===== pkg/smsp_pkg.sv
// Constants shared by the serial port design files
package smsp_pkg;
  // ---------------------------------------------
  // Register offsets on the special function bus
  // ---------------------------------------------
  localparam logic [7:0] TX_BYTE_BUFFER_ADDR = 8'h9A;
  localparam logic [7:0] RX_BYTE_BUFFER_ADDR = 8'h9B;
  localparam logic [7:0] SERIAL_CONFIG_ONE_ADDR = 8'hE8;
  localparam logic [7:0] SERIAL_CONFIG_TWO_ADDR = 8'hE9;
  localparam logic [7:0] SERIAL_IRQ_STATUS_ADDR = 8'hEA;
  // ---------------------------------------------
  // Reset values
  // ---------------------------------------------
  localparam logic [7:0] CONFIG_ONE_RESET = 8'h10;
  localparam logic [7:0] CONFIG_TWO_RESET = 8'h00;
  localparam logic [7:0] RX_BUFFER_RESET = 8'h00;
  // ---------------------------------------------
  // Field positions in serial_config_one
  // ---------------------------------------------
  localparam int CONTINUOUS_TRANSFER_ENABLE_BIT = 7;
  localparam int PORT_ENABLE_BIT = 6;
  localparam int IRQ_SOURCE_SELECT_BIT = 5;
  localparam int AUTO_SELECT_BIT = 4;
  localparam int SELECT_INPUT_ENABLE_BIT = 3;
  localparam int RECEIVE_OVERFLOW_WRITE_BIT = 2;
  localparam int BIT_RATE_DIVIDER_LSB = 0;
  // Field position in serial_config_two
  localparam int MASTER_MODE_BIT = 0;
  // Field positions in serial_irq_status
  localparam int RX_FULL_BIT = 0;
  localparam int TX_EMPTY_BIT = 1;
  localparam int RX_OVERFLOW_BIT = 2;
  // ---------------------------------------------
  // Timing
  // ---------------------------------------------
  // Half serial clock period for divider code 00, in core clocks
  localparam logic [5:0] HALF_PERIOD_BASE = 6'h04;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // Master sequencer states
  typedef enum logic [1:0] {smsp_idle, smsp_run, smsp_gap} smsp_state_t;
endpackage

// ===== design/smsp_clk_div.sv
// Serial clock divider giving one tick per half serial clock period
`timescale 1ns/1ps
module smsp_clk_div (
  input wire logic clock, // Core clock
  input wire logic srst, // Synchronous reset
  input wire logic run, // Count while high
  input wire logic [1:0] div_code, // Bit rate divider code
  output logic tick // One-cycle half period pulse
);
  logic [5:0] cnt_q;
  logic [5:0] limit;

  // Half period is 4, 8, 16 or 32 core clocks
  assign limit = smsp_pkg::HALF_PERIOD_BASE << div_code;

  // Free count that restarts whenever the sequencer stops
  always_ff @(posedge clock) begin
    if (srst || !run) begin
      cnt_q <= 6'h00;
    end else if (cnt_q == limit - 6'h01) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_q + 6'h01;
    end
  end

  assign tick = run && (cnt_q == limit - 6'h01);

  property p_div_eight;
    @(posedge clock) disable iff (srst)
      (tick && div_code == 2'h0) |=> (!tick)[*3] ##1 (tick || !run || div_code != 2'h0);
  endproperty
  a_div_eight: assert property (p_div_eight) else $error("half period not four clocks");
endmodule

// ===== design/smsp_rx_buffer.sv
// Receive holding stage with discard or overwrite on overflow
`timescale 1ns/1ps
module smsp_rx_buffer (
  input wire logic clock, // Core clock
  input wire logic srst, // Synchronous reset
  input wire logic push, // New received byte
  input wire logic [7:0] push_data, // Received byte
  input wire logic overwrite_en, // Replace unread byte
  input wire logic pop, // Software takes the byte
  output logic [7:0] hold_data, // Oldest unread byte
  output logic valid, // Holding stage full
  output logic overflow // One-cycle overflow pulse
);
  logic [7:0] data_q;
  logic valid_q;

  // Store policy: a pop frees room for a push in the same cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      data_q <= 8'h00;
      valid_q <= 1'b0;
    end else if (push && (!valid_q || pop || overwrite_en)) begin
      data_q <= push_data;
      valid_q <= 1'b1;
    end else if (pop) begin
      valid_q <= 1'b0;
    end
  end

  assign hold_data = data_q;
  assign valid = valid_q;
  assign overflow = push && valid_q && !pop;

  property p_discard;
    @(posedge clock) disable iff (srst)
      (push && valid_q && !pop && !overwrite_en) |=> (data_q == $past(data_q)) && valid_q;
  endproperty
  a_discard: assert property (p_discard) else $error("unread byte lost");

  property p_overwrite;
    @(posedge clock) disable iff (srst)
      (push && valid_q && overwrite_en) |=> data_q == $past(push_data);
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("byte not replaced");
endmodule

// ===== design/smsp_top.sv
// Byte-wide full-duplex serial port, master or slave, on the core register bus
`timescale 1ns/1ps
// What this block does
// - Eight bits shift out and in together each byte, full duplex.
// - Received byte stays readable while next byte shifts in.
// - Next transmit byte can be written while current byte shifts.
// - Works as master driving clock and select, or as slave.
// - Pins go to this port only while the pin select picks it.
// - Transmit register write queues the byte that is sent next.
// - Receive register read pops the oldest byte into that register.
// - Interrupt on receive full when source bit 0, transmit empty when 1.
// - Master with automatic select cleared holds select low.
// - Automatic select low for one byte then high in single mode.
// - Automatic select stays low across a continuous transfer.
// - Slave with select input enabled only works while select is low.
// - Overflow write bit 0 discards a new byte over an unread one.
// - Overflow write bit 1 replaces the unread byte.
// - Master clock is core clock over 8, 16, 32 or 64.
// - Reset: receive, config two, status zero; config one 0x10.
// - Port idles while its enable bit is clear.
// - Continuous master keeps going while transmit bytes are queued.
module smsp_top (
  input wire logic clock, // Core clock, 10 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic [7:0] sfr_addr, // Register address
  input wire logic sfr_wr, // Register write strobe
  input wire logic sfr_rd, // Register read strobe
  input wire logic [7:0] sfr_wdata, // Write data
  output logic [7:0] sfr_rdata, // Read data, one cycle after read
  input wire logic peripheral_pin_select, // High hands pins to I2C
  input wire logic sclk_i, // Serial clock pin level
  output logic sclk_o, // Serial clock drive
  output logic sclk_oe, // Serial clock enable
  input wire logic mosi_i, // Master out pin level
  output logic mosi_o, // Master out drive
  output logic mosi_oe, // Master out enable
  input wire logic miso_i, // Master in pin level
  output logic miso_o, // Master in drive
  output logic miso_oe, // Master in enable
  input wire logic ss_n_i, // Select pin level, low active
  output logic ss_n_o, // Select drive, low active
  output logic ss_n_oe, // Select enable
  output logic spi_irq // Interrupt request, level
);
  // ---------------------------------------------
  // Registers and decode
  // ---------------------------------------------
  logic [7:0] cfg1_q;
  logic [7:0] cfg2_q;
  logic [7:0] rx_buf_q;
  logic [7:0] rdata_q;
  logic ovf_q;
  logic [7:0] tx_hold_q;
  logic tx_full_q;
  logic tx_seen_q;
  logic wr_tx;
  logic rd_rx;
  logic port_enable;
  logic master;
  logic auto_sel;
  logic cont;
  logic spi_on;
  logic slave_sel;
  logic tx_pop;
  logic rx_push;
  logic [7:0] rx_push_data;
  logic [7:0] rx_hold;
  logic rx_valid;
  logic rx_ovf;
  logic tick;

  assign wr_tx = sfr_wr && sfr_addr == smsp_pkg::TX_BYTE_BUFFER_ADDR;
  assign rd_rx = sfr_rd && sfr_addr == smsp_pkg::RX_BYTE_BUFFER_ADDR;
  assign port_enable = cfg1_q[smsp_pkg::PORT_ENABLE_BIT];
  assign master = cfg2_q[smsp_pkg::MASTER_MODE_BIT];
  assign auto_sel = cfg1_q[smsp_pkg::AUTO_SELECT_BIT];
  assign cont = cfg1_q[smsp_pkg::CONTINUOUS_TRANSFER_ENABLE_BIT];
  assign spi_on = port_enable && !peripheral_pin_select;
  assign slave_sel = !cfg1_q[smsp_pkg::SELECT_INPUT_ENABLE_BIT] || !ss_n_i;

  // Configuration writes
  always_ff @(posedge clock) begin
    if (srst) begin
      cfg1_q <= smsp_pkg::CONFIG_ONE_RESET;
      cfg2_q <= smsp_pkg::CONFIG_TWO_RESET;
    end else if (sfr_wr && sfr_addr == smsp_pkg::SERIAL_CONFIG_ONE_ADDR) begin
      cfg1_q <= sfr_wdata;
    end else if (sfr_wr && sfr_addr == smsp_pkg::SERIAL_CONFIG_TWO_ADDR) begin
      cfg2_q <= sfr_wdata;
    end
  end

  // Overflow flag, set wins over a write-one clear
  always_ff @(posedge clock) begin
    if (srst) begin
      ovf_q <= 1'b0;
    end else if (rx_ovf) begin
      ovf_q <= 1'b1;
    end else if (sfr_wr && sfr_addr == smsp_pkg::SERIAL_IRQ_STATUS_ADDR
                 && sfr_wdata[smsp_pkg::RX_OVERFLOW_BIT]) begin
      ovf_q <= 1'b0;
    end
  end

  // Transmit holding byte; a write beats a same-cycle load into the shifter
  always_ff @(posedge clock) begin
    if (srst) begin
      tx_hold_q <= 8'h00;
      tx_full_q <= 1'b0;
      tx_seen_q <= 1'b0;
    end else if (wr_tx) begin
      tx_hold_q <= sfr_wdata;
      tx_full_q <= 1'b1;
      tx_seen_q <= 1'b1;
    end else if (tx_pop) begin
      tx_full_q <= 1'b0;
    end
  end

  // Read data and receive register pop
  always_ff @(posedge clock) begin
    if (srst) begin
      rx_buf_q <= smsp_pkg::RX_BUFFER_RESET;
      rdata_q <= 8'h00;
    end else if (rd_rx) begin
      rx_buf_q <= rx_valid ? rx_hold : rx_buf_q;
      rdata_q <= rx_valid ? rx_hold : rx_buf_q;
    end else if (sfr_rd && sfr_addr == smsp_pkg::SERIAL_CONFIG_ONE_ADDR) begin
      rdata_q <= cfg1_q;
    end else if (sfr_rd && sfr_addr == smsp_pkg::SERIAL_CONFIG_TWO_ADDR) begin
      rdata_q <= cfg2_q;
    end else if (sfr_rd && sfr_addr == smsp_pkg::SERIAL_IRQ_STATUS_ADDR) begin
      // Empty flag shows only once a byte was queued, so status reads zero after reset
      rdata_q <= {5'h00, ovf_q, tx_seen_q && !tx_full_q, rx_valid};
    end else if (sfr_rd) begin
      rdata_q <= 8'h00;
    end
  end
  assign sfr_rdata = rdata_q;

  // Interrupt source choice
  always_ff @(posedge clock) begin
    if (srst) begin
      spi_irq <= 1'b0;
    end else begin
      spi_irq <= port_enable && (cfg1_q[smsp_pkg::IRQ_SOURCE_SELECT_BIT] ?
                 !tx_full_q : rx_valid);
    end
  end

  smsp_rx_buffer u_rx (
    .clock(clock),
    .srst(srst),
    .push(rx_push),
    .push_data(rx_push_data),
    .overwrite_en(cfg1_q[smsp_pkg::RECEIVE_OVERFLOW_WRITE_BIT]),
    .pop(rd_rx),
    .hold_data(rx_hold),
    .valid(rx_valid),
    .overflow(rx_ovf)
  );

  // ---------------------------------------------
  // Shift engine
  // ---------------------------------------------
  smsp_pkg::smsp_state_t state_q;
  logic [7:0] tx_sh_q;
  logic [7:0] rx_sh_q;
  logic [2:0] bit_q;
  logic phase_q;
  logic sclk_int_q;
  logic sclk_prev_q;
  logic s_rise;
  logic s_fall;
  logic m_start;

  smsp_clk_div u_div (
    .clock(clock),
    .srst(srst),
    .run(spi_on && master && state_q != smsp_pkg::smsp_idle),
    .div_code(cfg1_q[smsp_pkg::BIT_RATE_DIVIDER_LSB +: 2]),
    .tick(tick)
  );

  assign s_rise = sclk_i && !sclk_prev_q;
  assign s_fall = !sclk_i && sclk_prev_q;
  assign m_start = master && state_q == smsp_pkg::smsp_idle && tx_full_q && !wr_tx;
  assign rx_push_data = master ? rx_sh_q : {rx_sh_q[6:0], mosi_i};
  assign rx_push = spi_on && (master ? (state_q == smsp_pkg::smsp_run && tick && phase_q
                   && bit_q == smsp_pkg::LAST_BIT) : (slave_sel && s_rise
                   && bit_q == smsp_pkg::LAST_BIT));
  assign tx_pop = spi_on && (m_start || (master && rx_push && cont && tx_full_q)
                  || (!master && slave_sel && s_rise && bit_q == 3'h0 && tx_full_q));

  // Slave clock history
  always_ff @(posedge clock) begin
    if (srst) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_i;
    end
  end

  // Master sequencer and slave shifting share one byte engine
  always_ff @(posedge clock) begin
    if (srst || !spi_on) begin
      state_q <= smsp_pkg::smsp_idle;
      tx_sh_q <= 8'h00;
      rx_sh_q <= 8'h00;
      bit_q <= 3'h0;
      phase_q <= 1'b0;
      sclk_int_q <= 1'b0;
    end else if (master) begin
      case (state_q)
        smsp_pkg::smsp_idle: begin
          if (m_start) begin
            tx_sh_q <= tx_hold_q;
            bit_q <= 3'h0;
            phase_q <= 1'b0;
            state_q <= smsp_pkg::smsp_run;
          end
        end
        smsp_pkg::smsp_run: begin
          if (tick && !phase_q) begin
            sclk_int_q <= 1'b1;
            rx_sh_q <= {rx_sh_q[6:0], miso_i};
            phase_q <= 1'b1;
          end else if (tick) begin
            sclk_int_q <= 1'b0;
            phase_q <= 1'b0;
            if (bit_q != smsp_pkg::LAST_BIT) begin
              bit_q <= bit_q + 3'h1;
              tx_sh_q <= {tx_sh_q[6:0], 1'b0};
            end else if (cont && tx_full_q) begin
              tx_sh_q <= tx_hold_q;
              bit_q <= 3'h0;
            end else begin
              state_q <= smsp_pkg::smsp_gap;
            end
          end
        end
        smsp_pkg::smsp_gap: begin
          if (tick) begin
            state_q <= smsp_pkg::smsp_idle;
          end
        end
        default: begin
          state_q <= smsp_pkg::smsp_idle;
        end
      endcase
    end else begin
      state_q <= smsp_pkg::smsp_idle;
      sclk_int_q <= 1'b0;
      if (!slave_sel) begin
        bit_q <= 3'h0;
      end else if (s_rise) begin
        rx_sh_q <= {rx_sh_q[6:0], mosi_i};
        bit_q <= bit_q + 3'h1;
      end else if (s_fall && bit_q != 3'h0) begin
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end else if (bit_q == 3'h0 && !sclk_i) begin
        tx_sh_q <= tx_full_q ? tx_hold_q : 8'h00;
      end
    end
  end

  // ---------------------------------------------
  // Pin drivers
  // ---------------------------------------------
  // Registered pin outputs; everything released while pins belong to I2C
  always_ff @(posedge clock) begin
    if (srst) begin
      sclk_o <= 1'b0;
      sclk_oe <= 1'b0;
      mosi_o <= 1'b0;
      mosi_oe <= 1'b0;
      miso_o <= 1'b0;
      miso_oe <= 1'b0;
      ss_n_o <= 1'b1;
      ss_n_oe <= 1'b0;
    end else begin
      sclk_o <= sclk_int_q;
      sclk_oe <= spi_on && master;
      mosi_o <= tx_sh_q[7];
      mosi_oe <= spi_on && master;
      miso_o <= tx_sh_q[7];
      miso_oe <= spi_on && !master && slave_sel;
      ss_n_o <= auto_sel ? (state_q == smsp_pkg::smsp_idle) : 1'b0;
      ss_n_oe <= spi_on && master;
    end
  end

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  property p_reset_vals;
    $fell(srst) |-> cfg1_q == 8'h10 && cfg2_q == 8'h00 && rx_buf_q == 8'h00 && !ovf_q;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

  property p_manual_sel;
    (spi_on && master && !auto_sel) |=> !ss_n_o && ss_n_oe;
  endproperty
  a_manual_sel: assert property (p_manual_sel) else $error("manual select not low");

  property p_auto_idle;
    (spi_on && master && auto_sel && state_q == smsp_pkg::smsp_idle) |=> ss_n_o;
  endproperty
  a_auto_idle: assert property (p_auto_idle) else $error("select low when idle");

  property p_auto_cont;
    (spi_on && master && auto_sel && rx_push && cont && tx_full_q) |=> ##1 !ss_n_o;
  endproperty
  a_auto_cont: assert property (p_auto_cont) else $error("select rose mid stream");

  property p_disabled;
    !port_enable |=> !sclk_oe && !mosi_oe && !miso_oe && !ss_n_oe;
  endproperty
  a_disabled: assert property (p_disabled) else $error("pins driven while off");

  property p_pins_i2c;
    peripheral_pin_select |=> !sclk_oe && !mosi_oe && !miso_oe && !ss_n_oe;
  endproperty
  a_pins_i2c: assert property (p_pins_i2c) else $error("pins driven in I2C mode");

  property p_irq_tx;
    (port_enable && cfg1_q[smsp_pkg::IRQ_SOURCE_SELECT_BIT] && !tx_full_q) |=> spi_irq;
  endproperty
  a_irq_tx: assert property (p_irq_tx) else $error("no empty interrupt");

  property p_irq_rx;
    (!cfg1_q[smsp_pkg::IRQ_SOURCE_SELECT_BIT]) |=> spi_irq == $past(port_enable && rx_valid);
  endproperty
  a_irq_rx: assert property (p_irq_rx) else $error("bad full interrupt");

  property p_tx_write;
    wr_tx |=> tx_full_q && tx_hold_q == $past(sfr_wdata);
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("write not queued");

  property p_rx_read;
    (rd_rx && rx_valid) |=> sfr_rdata == $past(rx_hold) && rx_buf_q == $past(rx_hold);
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("read did not pop");

  c_master_byte: cover property (master && rx_push);
  c_slave_byte: cover property (!master && rx_push);
  c_overflow: cover property (rx_ovf);
  c_continuous: cover property (master && rx_push && cont && tx_full_q);
endmodule

// ===== dv/smsp_partner.sv
// Behavioural serial slave device facing the port in master mode
`timescale 1ns/1ps
module smsp_partner (
  input wire logic sclk, // Serial clock pin
  input wire logic mosi, // Data from master
  input wire logic ss_n, // Select, low active
  input wire logic [7:0] reply, // Reply seed
  output logic miso, // Data to master
  output logic [7:0] rx_byte, // Last whole byte taken
  output logic [7:0] rx_cnt // Whole bytes taken
);
  logic [7:0] sh_in;
  logic [7:0] sh_out;
  logic [2:0] nbit;
  initial begin
    {miso, rx_byte, rx_cnt, sh_in, sh_out, nbit} = '0;
  end
  // Reply is seed xor byte count; its top bit shows on select
  always @(negedge ss_n) begin
    nbit = 3'h0;
    sh_out = reply ^ rx_cnt;
    miso = sh_out[7];
  end
  // Released line shows the inverse of its last bit
  always @(posedge ss_n) miso = ~miso;
  // Sample on rise, top bit first
  always @(posedge sclk) begin
    if (!ss_n) begin
      sh_in = {sh_in[6:0], mosi};
      nbit = nbit + 3'h1;
      if (nbit == 3'h0) begin
        rx_byte = sh_in;
        rx_cnt = rx_cnt + 8'h01;
      end
    end
  end
  // Shift on fall, next reply after a whole byte
  always @(negedge sclk) begin
    if (!ss_n) begin
      sh_out = (nbit == 3'h0) ? (reply ^ rx_cnt) : {sh_out[6:0], 1'b0};
      miso = sh_out[7];
    end
  end
endmodule

// ===== dv/smsp_top_tb.sv
// Self-checking bench for the serial port in master and slave use
`timescale 1ns/1ps
module smsp_top_tb;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic peripheral_pin_select = 1'b0;
  logic tb_sclk = 1'b0;
  logic tb_mosi = 1'b0;
  logic tb_ss_n = 1'b1;
  logic [7:0] sfr_rdata, rx_byte, rx_cnt, rd_val, tx, n, seed, got;
  logic sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe, spi_irq;
  logic sclk_pin, mosi_pin, miso_pin, ss_pin, dev_miso;
  logic prev_sclk = 1'b0;
  logic prev_ss = 1'b1;
  logic [31:0] rs = 32'h663D;
  int cyc = 0, rise_at = 0, half = 0, ss_rises = 0, miscompares = 0, n_tests = 0;
  // -------------------------------------------
  // Pins, instances and monitors
  // -------------------------------------------
  assign sclk_pin = sclk_oe ? sclk_o : tb_sclk;
  assign mosi_pin = mosi_oe ? mosi_o : tb_mosi;
  assign miso_pin = miso_oe ? miso_o : dev_miso;
  assign ss_pin = ss_n_oe ? ss_n_o : tb_ss_n;
  smsp_top i_smsp_top (.clock(clock), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .peripheral_pin_select(peripheral_pin_select), .sclk_i(sclk_pin), .sclk_o(sclk_o),
    .sclk_oe(sclk_oe), .mosi_i(mosi_pin), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .miso_i(miso_pin), .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_pin),
    .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe), .spi_irq(spi_irq));
  smsp_partner i_smsp_partner (.sclk(sclk_pin), .mosi(mosi_pin),
    .ss_n(ss_n_oe ? ss_n_o : 1'b1), .reply(seed), .miso(dev_miso), .rx_byte(rx_byte),
    .rx_cnt(rx_cnt));
  always #50 clock = ~clock;
  // Cycle count, timeout, clock high width and select releases
  always @(posedge clock) begin
    cyc <= cyc + 1;
    prev_sclk <= sclk_o;
    prev_ss <= ss_n_o;
    if (sclk_o && !prev_sclk) rise_at <= cyc;
    if (!sclk_o && prev_sclk) half <= cyc - rise_at;
    if (ss_n_o && !prev_ss && !srst) ss_rises <= ss_rises + 1;
    if (cyc == 60000) begin
      miscompares++;
      summarize();
    end
  end
  // -------------------------------------------
  // Helpers
  // -------------------------------------------
  function automatic logic [7:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clock);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clock);
    sfr_rd <= 1'b0;
    @(posedge clock);
    // Settle past the edge so registered outputs are read after update
    #1;
    rd_val = sfr_rdata;
  endtask
  // Wait for the device byte count, and for select release when asked
  task automatic wait_done(input logic [7:0] cnt, input logic idle_hi);
    int i;
    for (i = 0; i < 5000 && !(rx_cnt == cnt && (ss_n_o || !idle_hi)); i++) @(posedge clock);
    chk8(rx_cnt, cnt);
    repeat (40) @(posedge clock);
  endtask
  // Bench acting as external master, selecting the port or not
  task automatic sbyte(input logic [7:0] d, input logic sel, output logic [7:0] q);
    int b;
    @(posedge clock);
    tb_ss_n <= !sel;
    for (b = 7; b >= 0; b--) begin
      tb_mosi <= d[b];
      repeat (8) @(posedge clock);
      q = {q[6:0], miso_pin};
      tb_sclk <= 1'b1;
      repeat (8) @(posedge clock);
      tb_sclk <= 1'b0;
    end
    repeat (8) @(posedge clock);
    tb_ss_n <= 1'b1;
    tb_mosi <= ~tb_mosi;
    repeat (40) @(posedge clock);
  endtask
  task automatic summarize();
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // -------------------------------------------
  // Main sequence
  // -------------------------------------------
  initial begin
    seed = rnd();
    n = 8'h00;
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    rd(8'h9B);
    chk8(rd_val, 8'h00);
    rd(8'hE8);
    chk8(rd_val, 8'h10);
    rd(8'hE9);
    chk8(rd_val, 8'h00);
    rd(8'hEA);
    chk8(rd_val, 8'h00);
    rd(8'h00);
    chk8(rd_val, 8'h00);
    chk1(sclk_oe | mosi_oe | ss_n_oe, 1'b0);
    // Single master bytes at every divider code
    wr(8'hE9, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(8'hE8, 8'h50 | c[7:0]);
      tx = rnd();
      wr(8'h9A, tx);
      wait_done(n + 8'h01, 1'b1);
      chk8(rx_byte, tx);
      chk8(half[7:0], 8'h04 << c);
      chk1(spi_irq, 1'b1);
      rd(8'h9B);
      chk8(rd_val, seed ^ n);
      chk1(spi_irq, 1'b0);
      n++;
    end
    chk8(ss_rises[7:0], 8'h04);
    wr(8'hE8, 8'h70);
    repeat (2) @(posedge clock);
    chk1(spi_irq, 1'b1);
    // Continuous pairs, discard then overwrite on overflow
    for (int ow = 0; ow < 2; ow++) begin
      wr(8'hE8, ow ? 8'hD4 : 8'hD0);
      tx = rnd();
      wr(8'h9A, tx);
      wr(8'h9A, ~tx);
      wait_done(n + 8'h02, 1'b1);
      chk8(rx_byte, ~tx);
      chk8(ss_rises[7:0], 8'h05 + ow[7:0]);
      rd(8'h9B);
      chk8(rd_val, seed ^ (n + ow[7:0]));
      n = n + 8'h02;
    end
    // Manual select
    wr(8'hE8, 8'h40);
    tx = rnd();
    repeat (2) @(posedge clock);
    chk1(ss_n_o, 1'b0);
    wr(8'h9A, tx);
    wait_done(n + 8'h01, 1'b0);
    chk1(ss_n_o, 1'b0);
    chk8(rx_byte, tx);
    rd(8'h9B);
    chk8(rd_val, seed ^ n);
    n++;
    // Disabled port, then pins handed to the other unit
    wr(8'hE8, 8'h10);
    tx = rnd();
    wr(8'h9A, tx);
    repeat (200) @(posedge clock);
    chk8({sclk_oe, ss_n_oe, 2'b00, rx_cnt[3:0]}, {4'h0, n[3:0]});
    peripheral_pin_select <= 1'b1;
    wr(8'hE8, 8'h50);
    repeat (200) @(posedge clock);
    chk8({sclk_oe, mosi_oe, ss_n_oe, miso_oe, rx_cnt[3:0]}, {4'h0, n[3:0]});
    peripheral_pin_select <= 1'b0;
    wait_done(n + 8'h01, 1'b1);
    chk8(rx_byte, tx);
    rd(8'h9B);
    chk8(rd_val, seed ^ n);
    // Slave with select input, slow divider code set; reply byte queued first
    wr(8'hE9, 8'h00);
    wr(8'hE8, 8'h4B);
    tx = rnd();
    wr(8'h9A, seed);
    sbyte(tx, 1'b1, got);
    chk8(got, seed);
    chk1(spi_irq, 1'b1);
    rd(8'h9B);
    chk8(rd_val, tx);
    sbyte(~tx, 1'b0, got);
    chk1(spi_irq | miso_oe, 1'b0);
    summarize();
  end
endmodule
